// [aml_pkg.sv]
package aml_pkg;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] AML_IDX_LO_LOCK_MUTE = 16'hE101;
  localparam logic [15:0] AML_IDX_LO_RAMP_DIS = 16'hE103;
  localparam logic [15:0] AML_IDX_HI_LOCK_MUTE = 16'hE141;
  localparam logic [15:0] AML_IDX_HI_RAMP_DIS = 16'hE143;
  localparam logic [15:0] AML_IDX_IRQ_STATUS = 16'hE180;
  localparam logic [15:0] AML_IDX_IRQ_MASK = 16'hE181;

  localparam int AML_ADDR_W = 18;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int AML_MUTE_LSB = 0;
  localparam int AML_LOCK_LSB = 8;
  localparam int AML_RAMP_DIS_BIT = 0;
  localparam int AML_PAIRS_PER_GROUP = 4;
  localparam int AML_PAIRS = 8;
  // status/mask: [7:0] lock acquired, [15:8] master clock enabled
  localparam int AML_EVT_ACQ_LSB = 0;
  localparam int AML_EVT_MCLK_LSB = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] AML_RST_MUTE = 4'h0;
  localparam logic [7:0] AML_RST_LOCK = 8'h00;
  localparam logic AML_RST_RAMP_DIS = 1'b0;
  localparam logic [15:0] AML_RST_IRQ = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int AML_CLK_PERIOD_NS = 40;
  localparam int AML_RAMP_STEP_NS = 1000;
  localparam int AML_RAMP_STEP_CYC =
    (AML_RAMP_STEP_NS + AML_CLK_PERIOD_NS - 1) / AML_CLK_PERIOD_NS;
  localparam int AML_GAIN_W = 8;

  // 18-bit index-aligned byte address of a register index
  function automatic logic [AML_ADDR_W-1:0] aml_byte_addr(input logic [15:0] idx);
    aml_byte_addr = {idx, 2'b00};
  endfunction : aml_byte_addr

endpackage : aml_pkg

// [aml_sync.sv]
`timescale 1ns/1ps
module aml_sync
  import aml_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : aml_sync

// [aml_ramp.sv]
`timescale 1ns/1ps
module aml_ramp
  import aml_pkg::*;
#(
  parameter int GAIN_W = AML_GAIN_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_en,
  input wire logic mute_req,
  input wire logic abrupt,
  output logic [GAIN_W-1:0] gain,
  output logic silent
);

  localparam logic [GAIN_W-1:0] GAIN_FULL = '1;
  localparam logic [GAIN_W-1:0] GAIN_ONE = {{(GAIN_W-1){1'b0}}, 1'b1};

  // starts silent so no pop before the first unmute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain <= '0;
    end else if (abrupt) begin
      gain <= mute_req ? '0 : GAIN_FULL;
    end else if (step_en) begin
      if (mute_req && gain != '0) begin
        gain <= gain - GAIN_ONE;
      end else if (!mute_req && gain != GAIN_FULL) begin
        gain <= gain + GAIN_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      silent <= 1'b1;
    end else begin
      silent <= (gain == '0);
    end
  end

endmodule : aml_ramp

// [aml_mute_lock.sv]
`timescale 1ns/1ps
// What this block does
// - low nibble of each group register holds per-pair mute; 1 mutes, 0 unmutes
// - mute bit n drives pair n of its group; lower group bit 0 is pair 0
// - with ramping enabled, mute and unmute move the gain gradually
// - bits 11..8 are read-only lock flags, bit 8 lowest pair of group
// - upper group register has same layout for pairs 4 to 7
// - all lock flags read 0 after reset
// - master clock enable sets the pair's lock flag and forces mute
// - rate selected and locked clears the pair's lock flag
// - a cleared lock flag stays 0 until the next reset
// - lower ramp-disable bit 0: 0 ramps, 1 mutes abruptly, pairs 0 to 3
// - ramp-disable set ignores the group's software mute bits
// - upper ramp-disable register does the same for pairs 4 to 7
module aml_mute_lock
  import aml_pkg::*;
#(
  parameter int PAIRS = AML_PAIRS,
  parameter int GAIN_W = AML_GAIN_W,
  parameter int RAMP_STEP_CYC = AML_RAMP_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AML_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PAIRS-1:0] mclk_enable,
  input wire logic [PAIRS-1:0] rate_selected,
  input wire logic [PAIRS-1:0] clock_locked,
  output logic [PAIRS-1:0][GAIN_W-1:0] pair_gain,
  output logic [PAIRS-1:0] pair_silent,
  output logic [PAIRS-1:0] pair_mute_req,
  output logic irq
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic sel_lo_lm;
  logic sel_lo_rd;
  logic sel_hi_lm;
  logic sel_hi_rd;
  logic sel_stat;
  logic sel_mask;
  logic mapped;
  logic wr_en;
  logic rd_en;
  logic access;

  assign sel_lo_lm = (paddr == aml_byte_addr(AML_IDX_LO_LOCK_MUTE));
  assign sel_lo_rd = (paddr == aml_byte_addr(AML_IDX_LO_RAMP_DIS));
  assign sel_hi_lm = (paddr == aml_byte_addr(AML_IDX_HI_LOCK_MUTE));
  assign sel_hi_rd = (paddr == aml_byte_addr(AML_IDX_HI_RAMP_DIS));
  assign sel_stat = (paddr == aml_byte_addr(AML_IDX_IRQ_STATUS));
  assign sel_mask = (paddr == aml_byte_addr(AML_IDX_IRQ_MASK));
  assign mapped = sel_lo_lm | sel_lo_rd | sel_hi_lm | sel_hi_rd | sel_stat | sel_mask;

  assign access = psel & penable;
  assign wr_en = access & pwrite & mapped;
  assign rd_en = access & ~pwrite;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [3:0] mute_lo;
  logic [3:0] mute_hi;
  logic ramp_dis_lo;
  logic ramp_dis_hi;
  logic [15:0] irq_mask;

  // only byte lane 0 carries the mute nibble and ramp bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_lo <= AML_RST_MUTE;
    end else if (wr_en && sel_lo_lm && pstrb[0]) begin
      mute_lo <= pwdata[AML_MUTE_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_hi <= AML_RST_MUTE;
    end else if (wr_en && sel_hi_lm && pstrb[0]) begin
      mute_hi <= pwdata[AML_MUTE_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_dis_lo <= AML_RST_RAMP_DIS;
    end else if (wr_en && sel_lo_rd && pstrb[0]) begin
      ramp_dis_lo <= pwdata[AML_RAMP_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_dis_hi <= AML_RST_RAMP_DIS;
    end else if (wr_en && sel_hi_rd && pstrb[0]) begin
      ramp_dis_hi <= pwdata[AML_RAMP_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= AML_RST_IRQ;
    end else if (wr_en && sel_mask) begin
      if (pstrb[0]) begin
        irq_mask[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        irq_mask[15:8] <= pwdata[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // converter status inputs
  // ---------------------------------------------------------------
  // these come from converter logic on its own clocks
  logic [PAIRS-1:0] mclk_s;
  logic [PAIRS-1:0] rate_s;
  logic [PAIRS-1:0] locked_s;
  logic [PAIRS-1:0] mclk_d;
  logic [PAIRS-1:0] mclk_rise;

  aml_sync #(.WIDTH(PAIRS)) u_sync_mclk (
    .pclk(pclk),
    .presetn(presetn),
    .d(mclk_enable),
    .q(mclk_s)
  );

  aml_sync #(.WIDTH(PAIRS)) u_sync_rate (
    .pclk(pclk),
    .presetn(presetn),
    .d(rate_selected),
    .q(rate_s)
  );

  aml_sync #(.WIDTH(PAIRS)) u_sync_lock (
    .pclk(pclk),
    .presetn(presetn),
    .d(clock_locked),
    .q(locked_s)
  );

  // ---------------------------------------------------------------
  // master clock enable edge
  // ---------------------------------------------------------------
  // mclk_d clears with reset, so an enable already high at release
  // still counts as one event and arms the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_d <= '0;
    end else begin
      mclk_d <= mclk_s;
    end
  end

  assign mclk_rise = mclk_s & ~mclk_d;

  // ---------------------------------------------------------------
  // lock flags
  // ---------------------------------------------------------------
  logic [PAIRS-1:0] lock_flag;
  logic [PAIRS-1:0] lock_done;
  logic [PAIRS-1:0] lock_acq;

  // flag high means not yet locked; acquiring lock is one-way
  assign lock_acq = lock_flag & rate_s & locked_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_flag <= AML_RST_LOCK;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        if (mclk_rise[i] && !lock_done[i]) begin
          lock_flag[i] <= 1'b1;
        end else if (lock_acq[i]) begin
          lock_flag[i] <= 1'b0;
        end
      end
    end
  end

  // stays set until reset, so later rate or clock loss cannot re-arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_done <= '0;
    end else begin
      lock_done <= lock_done | lock_acq;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  logic [15:0] irq_status;
  logic [15:0] irq_set;
  logic [15:0] irq_clr;
  logic [15:0] next_irq_status;

  assign irq_set = {mclk_rise & ~lock_done, lock_acq};
  assign irq_clr = (wr_en && sel_stat) ?
                   (pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}}) : 16'h0000;

  // a new event beats a simultaneous write-one-to-clear
  assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= AML_RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // uses the next status so a clear drops irq at the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // step divider
  // ---------------------------------------------------------------
  // one gain step per RAMP_STEP_CYC clocks; a full swing is 2^GAIN_W-1 steps
  localparam int DIV_W = $clog2(RAMP_STEP_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RAMP_STEP_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

  logic [DIV_W-1:0] div_cnt;
  logic step_en;
  logic [PAIRS-1:0] sw_mute;
  logic [PAIRS-1:0] abrupt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      step_en <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
      step_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + DIV_ONE;
      step_en <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mute request
  // ---------------------------------------------------------------
  logic [PAIRS-1:0] sw_effective;

  assign sw_mute = {mute_hi, mute_lo};
  assign abrupt = {{AML_PAIRS_PER_GROUP{ramp_dis_hi}}, {AML_PAIRS_PER_GROUP{ramp_dis_lo}}};

  // without ramping only lack of lock mutes
  assign sw_effective = sw_mute & ~abrupt;

  // held muted through reset so nothing is heard before the first decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_mute_req <= '1;
    end else begin
      pair_mute_req <= sw_effective | lock_flag;
    end
  end

  // ---------------------------------------------------------------
  // gain ramps
  // ---------------------------------------------------------------
  for (genvar g = 0; g < PAIRS; g++) begin : g_ramp
    aml_ramp #(.GAIN_W(GAIN_W)) u_ramp (
      .pclk(pclk),
      .presetn(presetn),
      .step_en(step_en),
      .mute_req(pair_mute_req[g]),
      .abrupt(abrupt[g]),
      .gain(pair_gain[g]),
      .silent(pair_silent[g])
    );
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [3:0] lock_lo;
  logic [3:0] lock_hi;

  // one group's lock/mute word; reserved positions stay zero
  function automatic logic [31:0] aml_lm_word(input logic [3:0] lock, input logic [3:0] mute);
    aml_lm_word = 32'h0000_0000;
    aml_lm_word[AML_LOCK_LSB +: 4] = lock;
    aml_lm_word[AML_MUTE_LSB +: 4] = mute;
  endfunction : aml_lm_word

  // pair n of either group shows at the same bit of its word
  assign lock_lo = lock_flag[3:0];
  assign lock_hi = lock_flag[7:4];

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_lo_lm) begin
      next_rdata = aml_lm_word(lock_lo, mute_lo);
    end else if (sel_hi_lm) begin
      next_rdata = aml_lm_word(lock_hi, mute_hi);
    end else if (sel_lo_rd) begin
      next_rdata[AML_RAMP_DIS_BIT] = ramp_dis_lo;
    end else if (sel_hi_rd) begin
      next_rdata[AML_RAMP_DIS_BIT] = ramp_dis_hi;
    end else if (sel_stat) begin
      next_rdata[15:0] = irq_status;
    end else if (sel_mask) begin
      next_rdata[15:0] = irq_mask;
    end
  end

  // driven in the setup cycle so it is valid at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end else if (rd_en) begin
      prdata <= prdata;
    end
  end

endmodule : aml_mute_lock

// [aml_mute_lock_assertions.sv]
`timescale 1ns/1ps
module aml_mute_lock_assertions
  import aml_pkg::*;
#(
  parameter int PAIRS = AML_PAIRS,
  parameter int GAIN_W = AML_GAIN_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AML_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PAIRS-1:0][GAIN_W-1:0] pair_gain,
  input wire logic [PAIRS-1:0] pair_silent,
  input wire logic [PAIRS-1:0] pair_mute_req,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mask_clr;
  logic [GAIN_W-1:0] g0;
  assign g0 = pair_gain[0];
  assign mask_clr = psel && penable && pwrite && pstrb[1:0] == 2'h3 && pwdata[15:0] == 16'h0
    && paddr == {AML_IDX_IRQ_MASK, 2'b00};
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ready_now_a: assert property (psel |-> pready) else $error("pready low");
  rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved outside read setup");
  unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  ramp_step_a: assert property ($changed(g0) |-> g0 == $past(g0) + 1'b1 ||
    g0 == $past(g0) - 1'b1 || g0 == '0 || g0 == '1) else $error("gain jumped");
  mute_fall_a: assert property (pair_mute_req[0] [*3] |-> g0 <= $past(g0))
    else $error("gain rose while muted");
  unmute_rise_a: assert property (!pair_mute_req[0] [*3] |-> g0 >= $past(g0))
    else $error("gain fell while unmuted");
  silent_track_a: assert property (pair_silent[0] == ($past(g0) == '0))
    else $error("silent flag wrong");
  irq_mask_a: assert property (mask_clr |-> ##2 !irq) else $error("irq high with mask clear");
  cover property ($rose(irq));
  cover property (g0 == '1);
  cover property (pslverr);
endmodule : aml_mute_lock_assertions

bind aml_mute_lock aml_mute_lock_assertions #(.PAIRS(PAIRS), .GAIN_W(GAIN_W)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pair_gain(pair_gain), .pair_silent(pair_silent),
  .pair_mute_req(pair_mute_req), .irq(irq));

// [tb_asrc_mute_lock_control.sv]
`timescale 1ns/1ps
module tb_asrc_mute_lock_control;
  import aml_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [AML_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, irq;
  logic [7:0] mclk_enable = '0, rate_selected = '0, clock_locked = '0;
  logic [7:0][7:0] pair_gain;
  logic [7:0] pair_silent, pair_mute_req, lockf = '0, sw = '0;
  logic [1:0] rd = '0;
  logic [32:0] q[$];
  int n_errors = 0, n_tests = 0, seed = 32'h13243036;
  aml_mute_lock #(.RAMP_STEP_CYC(2)) aml_mute_lock_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mclk_enable(mclk_enable), .rate_selected(rate_selected), .clock_locked(clock_locked),
    .pair_gain(pair_gain), .pair_silent(pair_silent), .pair_mute_req(pair_mute_req), .irq(irq));
  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] dt,
                     input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= dt;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [32:0] lm(input int g);
    lm = {21'h0, lockf[g*4+:4], 4'h0, sw[g*4+:4]};
  endfunction : lm
  task automatic chk_mute();
    repeat (6) @(posedge pclk);
    cmp("mute_req", {25'h0, lockf | (sw & ~{{4{rd[1]}}, {4{rd[0]}}})}, {25'h0, pair_mute_req});
  endtask : chk_mute
  task automatic chk_locks(input string nm);
    apb(1'b0, AML_IDX_LO_LOCK_MUTE, 0, lm(0));
    apb(1'b0, AML_IDX_HI_LOCK_MUTE, 0, lm(1));
    $display("test %s done", nm);
  endtask : chk_locks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) cmp("read", q.pop_front(), {pslverr, prdata});
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_locks("reset");
    apb(1'b0, AML_IDX_LO_RAMP_DIS, 0, 33'h0);
    apb(1'b0, AML_IDX_HI_RAMP_DIS, 0, 33'h0);
    apb(1'b0, 16'hE102, 0, {1'b1, 32'h0});
    apb(1'b1, AML_IDX_IRQ_MASK, 32'hFFFF, 0);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      sw = d[7:0];
      rd = d[9:8];
      apb(1'b1, AML_IDX_LO_LOCK_MUTE, {d[31:4], sw[3:0]}, 0);
      apb(1'b1, AML_IDX_HI_LOCK_MUTE, {d[31:4], sw[7:4]}, 0);
      apb(1'b1, AML_IDX_LO_RAMP_DIS, {d[31:1], rd[0]}, 0);
      apb(1'b1, AML_IDX_HI_RAMP_DIS, {d[31:1], rd[1]}, 0);
      apb(1'b0, AML_IDX_LO_RAMP_DIS, 0, {32'h0, rd[0]});
      apb(1'b0, AML_IDX_HI_RAMP_DIS, 0, {32'h0, rd[1]});
      chk_locks("layout");
      chk_mute();
    end
    mclk_enable <= 8'hFF;
    lockf = 8'hFF;
    repeat (8) @(posedge pclk);
    chk_locks("clock enable");
    chk_mute();
    cmp("irq", 33'h1, {32'h0, irq});
    apb(1'b0, AML_IDX_IRQ_STATUS, 0, 33'hFF00);
    apb(1'b1, AML_IDX_IRQ_MASK, 0, 0);
    @(posedge pclk); // irq follows a mask write one edge later
    cmp("irq masked", 33'h0, {32'h0, irq});
    apb(1'b1, AML_IDX_IRQ_STATUS, 32'hFF00, 0);
    apb(1'b0, AML_IDX_IRQ_STATUS, 0, 33'h0);
    apb(1'b1, AML_IDX_IRQ_MASK, 32'hFFFF, 0);
    rate_selected <= 8'h21;
    clock_locked <= 8'h21;
    lockf = 8'hDE;
    repeat (8) @(posedge pclk);
    chk_locks("lock");
    cmp("irq lock", 33'h1, {32'h0, irq});
    apb(1'b0, AML_IDX_IRQ_STATUS, 0, 33'h0021);
    apb(1'b1, AML_IDX_IRQ_STATUS, 32'hFFFF, 0);
    cmp("irq clear", 33'h0, {32'h0, irq});
    clock_locked <= 8'h0;
    rate_selected <= 8'h0;
    mclk_enable <= 8'hDE;
    repeat (6) @(posedge pclk);
    mclk_enable <= 8'hFF;
    repeat (8) @(posedge pclk);
    chk_locks("sticky");
    sw = 8'h0;
    rd = 2'h0;
    apb(1'b1, AML_IDX_LO_RAMP_DIS, 0, 0);
    apb(1'b1, AML_IDX_HI_RAMP_DIS, 0, 0);
    apb(1'b1, AML_IDX_LO_LOCK_MUTE, 32'h1, 0);
    apb(1'b1, AML_IDX_HI_LOCK_MUTE, 0, 0);
    repeat (600) @(posedge pclk);
    cmp("ramp floor", {24'h0, 9'h100}, {24'h0, pair_silent[0], pair_gain[0]});
    apb(1'b1, AML_IDX_LO_LOCK_MUTE, 0, 0);
    repeat (30) @(posedge pclk);
    cmp("mid ramp up", 33'h1, {32'h0, pair_gain[0] > 8'h00 && pair_gain[0] < 8'hFF});
    repeat (600) @(posedge pclk);
    cmp("gain up", {24'h0, 9'h0FF}, {24'h0, pair_silent[0], pair_gain[0]});
    sw[0] = 1'b1;
    apb(1'b1, AML_IDX_LO_LOCK_MUTE, 32'h1, 0);
    repeat (30) @(posedge pclk);
    cmp("mid ramp down", 33'h1, {32'h0, pair_gain[0] > 8'h00 && pair_gain[0] < 8'hFF});
    repeat (600) @(posedge pclk);
    cmp("gain down", {24'h0, 9'h100}, {24'h0, pair_silent[0], pair_gain[0]});
    rd[0] = 1'b1;
    apb(1'b1, AML_IDX_LO_RAMP_DIS, 32'h1, 0);
    repeat (4) @(posedge pclk);
    cmp("abrupt", {25'h0, 8'hFF}, {25'h0, pair_gain[0]});
    chk_mute();
    sw[5] = 1'b1;
    rd[1] = 1'b1;
    apb(1'b1, AML_IDX_HI_RAMP_DIS, 32'h1, 0);
    apb(1'b1, AML_IDX_HI_LOCK_MUTE, 32'h2, 0);
    chk_mute();
    $display("test ramp done");
    tally_and_finish();
  end
endmodule : tb_asrc_mute_lock_control
